// file: hdl/mrb_crc16.v
// one byte step of the modbus crc-16
`default_nettype none
`include "mrb_defs.vh"
module mrb_crc16 (
  input wire [15:0] crcIn,
  input wire [7:0] dataIn,
  output reg [15:0] crcOut
);
  integer i;
  always @* begin
    crcOut = crcIn ^ {8'h00, dataIn};
    for (i = 0; i < 8; i = i + 1) begin
      if (crcOut[0]) begin
        crcOut = (crcOut >> 1) ^ `MRB_CRC_POLY;
      end else begin
        crcOut = crcOut >> 1;
      end
    end
  end
endmodule // mrb_crc16
`default_nettype wire

// file: hdl/mrb_defs.vh
// shared constants for the monitor modbus register interface
`ifndef MRB_DEFS_VH
`define MRB_DEFS_VH
`define MRB_REG_ID 16'h0000
`define MRB_REG_OPT 16'h0014
`define MRB_REG_CMD 16'h0015
`define MRB_REG_FLT 16'h001C
`define MRB_REG_STATE 16'h001E
`define MRB_REG_COND 16'h001F
`define MRB_REG_CLEAN 16'h0038
`define MRB_OPT_RESET 16'h0000
`define MRB_OPT_MASK 16'h019F
`define MRB_OPT_LOWFLOW 8
`define MRB_FLT_RESET 5'h00
`define MRB_CMD_START 16'h0001
`define MRB_CMD_RECALC 16'h0002
`define MRB_CMD_A_ON 16'h0003
`define MRB_CMD_A_OFF 16'h0004
`define MRB_CMD_B_ON 16'h0005
`define MRB_CMD_B_OFF 16'h0006
`define MRB_CMD_EXER_ON 16'h0007
`define MRB_CMD_EXER_OFF 16'h0008
`define MRB_CMD_STOP 16'h0009
`define MRB_CMD_ERASE 16'h000A
`define MRB_CMD_SEEK_END 16'h000B
`define MRB_CMD_STEP_BACK 16'h000C
`define MRB_FN_READ 8'h04
`define MRB_FN_WRITE 8'h06
`define MRB_MAX_REGS 16'h007D
`define MRB_CRC_INIT 16'hFFFF
`define MRB_CRC_POLY 16'hA001
`define MRB_REQ_LEN 4'h8
`define MRB_HEAD_READ 3'h3
`define MRB_HEAD_WRITE 3'h6
`define MRB_CLK_NS 10
`define MRB_GAP_NS 1750000
`define MRB_BLINK_NS 250000000
`endif

// file: hdl/mrb_fifo.v
// byte fifo between the response builder and the line transmitter
`default_nettype none
module mrb_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 32,
  parameter AW = 5
) (
  input wire sys_clk,
  input wire resetn,
  input wire inValid,
  output wire inReady,
  input wire [WIDTH-1:0] inData,
  output wire outValid,
  input wire outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_q;
  reg [AW-1:0] rdPtr_q;
  reg [AW:0] count_q;
  wire doPush;
  wire doPop;
  assign inReady = (count_q != DEPTH[AW:0]);
  assign outValid = (count_q != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_q];
  assign doPush = inValid & inReady;
  assign doPop = outValid & outReady;
  always @(posedge sys_clk) begin
    if (doPush) begin
      mem[wrPtr_q] <= inData;
    end
  end
  always @(posedge sys_clk) begin
    if (!resetn) begin
      wrPtr_q <= {AW{1'b0}};
      rdPtr_q <= {AW{1'b0}};
      count_q <= {(AW+1){1'b0}};
    end else begin
      if (doPush) begin
        wrPtr_q <= (wrPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          wrPtr_q + 1'b1;
      end
      if (doPop) begin
        rdPtr_q <= (rdPtr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
          rdPtr_q + 1'b1;
      end
      if (doPush & ~doPop) begin
        count_q <= count_q + 1'b1;
      end else if (doPop & ~doPush) begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule // mrb_fifo
`default_nettype wire

// file: hdl/mrb_top.v
// modbus register interface of the contamination monitor
// Summary of operation
// - option register clears to zero at reset
// - option bits are independent test option controls
// - option bit 8 suppresses low-flow alarms
// - register 21 writes execute, never stored
// - codes 1-6 and 10-12 trigger functions
// - code 9 aborts running test
// - code 7 enters exercise mode, 8 leaves
// - register 30 reads operating state code
// - register 31 bits 0-2 report outcome
// - bit 3 testing, bit 4 test complete
// - bits 5-10 alarms drive relay outputs
// - bit 11 set under modbus control
// - bits 12-14 mirror start and relays
// - register 28 holds five fault flags
// - faults hold until next test end
// - frames are sent as gapless byte runs
// - full read answers with 255-byte frame
// - up to 125 registers, ascending order
// - each register sent high byte first
// - register 0 holds product identifier
// - register 56 holds cleanliness class code
// - 32-bit values: upper half lower register
`default_nettype none
`include "mrb_defs.vh"
module mrb_top #(
  parameter [15:0] ID_CODE = 16'h1234, // arbitrary value
  parameter [31:0] GAP_CYCLES = `MRB_GAP_NS / `MRB_CLK_NS,
  parameter [31:0] BLINK_CYCLES = `MRB_BLINK_NS / `MRB_CLK_NS,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW = 5
) (
  input wire sys_clk,
  input wire resetn,
  input wire rxValid,
  input wire [7:0] rxByte,
  input wire txReady,
  output reg txValid_q,
  output reg [7:0] txByte_q,
  input wire [7:0] slaveAddr,
  input wire startLinePin,
  input wire [15:0] stateCode,
  input wire [2:0] resultFlags,
  input wire testDone,
  input wire [5:0] alarmIn,
  input wire [4:0] faultDetect,
  input wire [15:0] cleanCode,
  input wire lowFlowRaw,
  output reg [15:0] optionBits_q,
  output reg startTest_q,
  output reg recomputeOutcome_q,
  output reg abortTest_q,
  output reg recordErase_q,
  output reg recordSeekEnd_q,
  output reg recordStepBack_q,
  output reg testRunning_q,
  output reg exerciseMode_q,
  output reg ledFlash_q,
  output reg relayAState_q,
  output reg relayBState_q,
  output reg lowFlowAlarm_q
);
  localparam [3:0] ST_IDLE = 4'b0001;
  localparam [3:0] ST_HEAD = 4'b0010;
  localparam [3:0] ST_DATA = 4'b0100;
  localparam [3:0] ST_CRC = 4'b1000;

  reg startSync1_q;
  reg startLineState_q;
  reg [31:0] gapCnt_q;
  reg [3:0] rxCnt_q;
  reg [15:0] rxCrc_q;
  reg [55:0] rxBuf_q;
  reg reqValid_q;
  reg [7:0] reqFn_q;
  reg [15:0] reqReg_q;
  reg [15:0] reqVal_q;
  reg [3:0] state_q;
  reg [2:0] headIdx_q;
  reg [2:0] headLen_q;
  reg [7:0] regsLeft_q;
  reg [15:0] regIdx_q;
  reg hiSel_q;
  reg crcSel_q;
  reg [15:0] txCrc_q;
  reg [15:0] respReg_q;
  reg [15:0] respVal_q;
  reg [7:0] respFn_q;
  reg [4:0] faults_q;
  reg testComplete_q;
  reg remote_q;
  reg forceA_q;
  reg forceAVal_q;
  reg forceB_q;
  reg forceBVal_q;
  reg [31:0] blinkCnt_q;
  reg [15:0] readData;
  reg [7:0] pushByte;
  wire gapExpired;
  wire newFrame;
  wire [15:0] rxCrcIn;
  wire [15:0] rxCrcNext;
  wire [15:0] txCrcNext;
  wire [63:0] frame;
  wire fifoInValid;
  wire fifoInReady;
  wire fifoOutValid;
  wire fifoOutReady;
  wire [7:0] fifoOutData;
  wire push;
  wire [15:0] condFlags;
  wire writeReq;
  wire cmdReq;

  // start line is a pin: two flops before use
  always @(posedge sys_clk) begin
    if (!resetn) begin
      startSync1_q <= 1'b0;
      startLineState_q <= 1'b0;
    end else begin
      startSync1_q <= startLinePin;
      startLineState_q <= startSync1_q;
    end
  end

  // silence on the line ends a partial frame
  assign gapExpired = (gapCnt_q >= GAP_CYCLES);
  assign newFrame = gapExpired | (rxCnt_q == `MRB_REQ_LEN);
  assign rxCrcIn = newFrame ? `MRB_CRC_INIT : rxCrc_q;
  assign frame = {rxBuf_q, rxByte};

  mrb_crc16 rxCrcStep (
    .crcIn(rxCrcIn),
    .dataIn(rxByte),
    .crcOut(rxCrcNext)
  );

  always @(posedge sys_clk) begin
    if (!resetn) begin
      gapCnt_q <= GAP_CYCLES;
      rxCnt_q <= 4'h0;
      rxCrc_q <= `MRB_CRC_INIT;
      rxBuf_q <= 56'h0;
      reqValid_q <= 1'b0;
      reqFn_q <= 8'h00;
      reqReg_q <= 16'h0000;
      reqVal_q <= 16'h0000;
    end else begin
      reqValid_q <= 1'b0;
      if (rxValid) begin
        gapCnt_q <= 32'h0;
        rxCrc_q <= rxCrcNext;
        rxBuf_q <= frame[55:0];
        rxCnt_q <= newFrame ? 4'h1 : rxCnt_q + 4'h1;
        // residue zero means the crc closes
        if (!newFrame && rxCnt_q == `MRB_REQ_LEN - 4'h1 &&
            rxCrcNext == 16'h0000 && frame[63:56] == slaveAddr) begin
          reqValid_q <= 1'b1;
          reqFn_q <= frame[55:48];
          reqReg_q <= frame[47:32];
          reqVal_q <= frame[31:16];
        end
      end else if (!gapExpired) begin
        gapCnt_q <= gapCnt_q + 32'h1;
      end
    end
  end

  assign condFlags = {1'b0, relayBState_q, relayAState_q,
    startLineState_q, remote_q,
    alarmIn,
    testComplete_q, testRunning_q,
    resultFlags};

  // register read map; unmapped registers read zero
  always @* begin
    case (regIdx_q)
      `MRB_REG_ID: readData = ID_CODE;
      `MRB_REG_OPT: readData = optionBits_q;
      `MRB_REG_FLT: readData = {11'h000, faults_q};
      `MRB_REG_STATE: readData = stateCode;
      `MRB_REG_COND: readData = condFlags;
      `MRB_REG_CLEAN: readData = cleanCode;
      default: readData = 16'h0000;
    endcase
  end

  // response byte for the current builder position
  always @* begin
    pushByte = 8'h00;
    case (state_q)
      ST_HEAD: begin
        case (headIdx_q)
          3'h0: pushByte = slaveAddr;
          3'h1: pushByte = respFn_q;
          3'h2: pushByte = (respFn_q == `MRB_FN_READ) ?
            {regsLeft_q[6:0], 1'b0} : respReg_q[15:8];
          3'h3: pushByte = respReg_q[7:0];
          3'h4: pushByte = respVal_q[15:8];
          default: pushByte = respVal_q[7:0];
        endcase
      end
      ST_DATA: pushByte = hiSel_q ? readData[15:8] :
        readData[7:0];
      ST_CRC: pushByte = crcSel_q ? txCrc_q[15:8] : txCrc_q[7:0];
      default: pushByte = 8'h00;
    endcase
  end

  mrb_crc16 txCrcStep (
    .crcIn(txCrc_q),
    .dataIn(pushByte),
    .crcOut(txCrcNext)
  );

  assign fifoInValid = (state_q != ST_IDLE);
  assign push = fifoInValid & fifoInReady;
  assign writeReq = reqValid_q & (state_q == ST_IDLE) &
    (reqFn_q == `MRB_FN_WRITE);
  assign cmdReq = writeReq & (reqReg_q == `MRB_REG_CMD);

  // response builder; the fifo absorbs line back-pressure
  always @(posedge sys_clk) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      headIdx_q <= 3'h0;
      headLen_q <= `MRB_HEAD_READ;
      regsLeft_q <= 8'h00;
      regIdx_q <= 16'h0000;
      hiSel_q <= 1'b1;
      crcSel_q <= 1'b0;
      txCrc_q <= `MRB_CRC_INIT;
      respFn_q <= 8'h00;
      respReg_q <= 16'h0000;
      respVal_q <= 16'h0000;
    end else begin
      case (state_q)
        ST_IDLE: begin
          headIdx_q <= 3'h0;
          hiSel_q <= 1'b1;
          crcSel_q <= 1'b0;
          txCrc_q <= `MRB_CRC_INIT;
          respFn_q <= reqFn_q;
          respReg_q <= reqReg_q;
          respVal_q <= reqVal_q;
          regIdx_q <= reqReg_q;
          regsLeft_q <= reqVal_q[7:0];
          if (reqValid_q && reqFn_q == `MRB_FN_READ &&
              reqVal_q != 16'h0000 && reqVal_q <= `MRB_MAX_REGS) begin
            headLen_q <= `MRB_HEAD_READ;
            state_q <= ST_HEAD;
          end else if (writeReq) begin
            headLen_q <= `MRB_HEAD_WRITE;
            regsLeft_q <= 8'h00;
            state_q <= ST_HEAD;
          end
        end
        ST_HEAD: begin
          if (push) begin
            txCrc_q <= txCrcNext;
            headIdx_q <= headIdx_q + 3'h1;
            if (headIdx_q == headLen_q - 3'h1) begin
              state_q <= (regsLeft_q != 8'h00) ? ST_DATA : ST_CRC;
            end
          end
        end
        ST_DATA: begin
          if (push) begin
            txCrc_q <= txCrcNext;
            hiSel_q <= ~hiSel_q;
            if (!hiSel_q) begin
              regIdx_q <= regIdx_q + 16'h0001;
              regsLeft_q <= regsLeft_q - 8'h01;
              if (regsLeft_q == 8'h01) begin
                state_q <= ST_CRC;
              end
            end
          end
        end
        ST_CRC: begin
          if (push) begin
            crcSel_q <= ~crcSel_q;
            if (crcSel_q) begin
              state_q <= ST_IDLE;
            end
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  mrb_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) txFifo (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .inValid(fifoInValid),
    .inReady(fifoInReady),
    .inData(pushByte),
    .outValid(fifoOutValid),
    .outReady(fifoOutReady),
    .outData(fifoOutData)
  );

  assign fifoOutReady = ~txValid_q | txReady;

  always @(posedge sys_clk) begin
    if (!resetn) begin
      txValid_q <= 1'b0;
      txByte_q <= 8'h00;
    end else if (fifoOutReady) begin
      txValid_q <= fifoOutValid;
      if (fifoOutValid) begin
        txByte_q <= fifoOutData;
      end
    end
  end

  // register writes and action codes
  always @(posedge sys_clk) begin
    if (!resetn) begin
      optionBits_q <= `MRB_OPT_RESET;
      startTest_q <= 1'b0;
      recomputeOutcome_q <= 1'b0;
      abortTest_q <= 1'b0;
      recordErase_q <= 1'b0;
      recordSeekEnd_q <= 1'b0;
      recordStepBack_q <= 1'b0;
      exerciseMode_q <= 1'b0;
      forceA_q <= 1'b0;
      forceAVal_q <= 1'b0;
      forceB_q <= 1'b0;
      forceBVal_q <= 1'b0;
      remote_q <= 1'b0;
    end else begin
      startTest_q <= 1'b0;
      recomputeOutcome_q <= 1'b0;
      abortTest_q <= 1'b0;
      recordErase_q <= 1'b0;
      recordSeekEnd_q <= 1'b0;
      recordStepBack_q <= 1'b0;
      if (reqValid_q) begin
        remote_q <= 1'b1;
      end
      if (writeReq && reqReg_q == `MRB_REG_OPT) begin
        optionBits_q <= reqVal_q & `MRB_OPT_MASK;
      end
      if (cmdReq) begin
        case (reqVal_q)
          `MRB_CMD_START: startTest_q <= 1'b1;
          `MRB_CMD_RECALC: recomputeOutcome_q <= 1'b1;
          `MRB_CMD_A_ON: begin
            forceA_q <= 1'b1;
            forceAVal_q <= 1'b1;
          end
          `MRB_CMD_A_OFF: begin
            forceA_q <= 1'b1;
            forceAVal_q <= 1'b0;
          end
          `MRB_CMD_B_ON: begin
            forceB_q <= 1'b1;
            forceBVal_q <= 1'b1;
          end
          `MRB_CMD_B_OFF: begin
            forceB_q <= 1'b1;
            forceBVal_q <= 1'b0;
          end
          `MRB_CMD_EXER_ON: exerciseMode_q <= 1'b1;
          `MRB_CMD_EXER_OFF: exerciseMode_q <= 1'b0;
          `MRB_CMD_STOP: abortTest_q <= 1'b1;
          `MRB_CMD_ERASE: recordErase_q <= 1'b1;
          `MRB_CMD_SEEK_END: recordSeekEnd_q <= 1'b1;
          `MRB_CMD_STEP_BACK: recordStepBack_q <= 1'b1;
          default: remote_q <= 1'b1;
        endcase
      end
    end
  end

  // test progress, faults, relays and exercise blink
  always @(posedge sys_clk) begin
    if (!resetn) begin
      testRunning_q <= 1'b0;
      testComplete_q <= 1'b0;
      faults_q <= `MRB_FLT_RESET;
      blinkCnt_q <= 32'h0;
      ledFlash_q <= 1'b0;
      relayAState_q <= 1'b0;
      relayBState_q <= 1'b0;
      lowFlowAlarm_q <= 1'b0;
    end else begin
      if (startTest_q) begin
        testRunning_q <= 1'b1;
        testComplete_q <= 1'b0;
      end else if (abortTest_q) begin
        testRunning_q <= 1'b0;
      end else if (testDone && testRunning_q) begin
        testRunning_q <= 1'b0;
        testComplete_q <= 1'b1;
      end
      // a fault seen in the closing cycle still sets
      if (testDone) begin
        faults_q <= faultDetect;
      end else begin
        faults_q <= faults_q | faultDetect;
      end
      lowFlowAlarm_q <= lowFlowRaw &
        ~optionBits_q[`MRB_OPT_LOWFLOW];
      if (!exerciseMode_q) begin
        blinkCnt_q <= 32'h0;
        ledFlash_q <= 1'b0;
      end else if (blinkCnt_q >= BLINK_CYCLES - 32'h1) begin
        blinkCnt_q <= 32'h0;
        ledFlash_q <= ~ledFlash_q;
      end else begin
        blinkCnt_q <= blinkCnt_q + 32'h1;
      end
      if (exerciseMode_q) begin
        relayAState_q <= ledFlash_q;
        relayBState_q <= ~ledFlash_q;
      end else begin
        relayAState_q <= forceA_q ? forceAVal_q :
          |alarmIn[2:0];
        relayBState_q <= forceB_q ? forceBVal_q : |alarmIn[5:3];
      end
    end
  end
endmodule // mrb_top
`default_nettype wire

// file: tb/mrb_assertions.sv
// concurrent checks on the register interface ports
`default_nettype none
module mrb_assertions (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic txReady,
  input wire logic txValid_q,
  input wire logic [7:0] txByte_q,
  input wire logic lowFlowRaw,
  input wire logic [15:0] optionBits_q,
  input wire logic startTest_q,
  input wire logic recomputeOutcome_q,
  input wire logic abortTest_q,
  input wire logic recordErase_q,
  input wire logic recordSeekEnd_q,
  input wire logic recordStepBack_q,
  input wire logic testRunning_q,
  input wire logic exerciseMode_q,
  input wire logic ledFlash_q,
  input wire logic relayAState_q,
  input wire logic relayBState_q,
  input wire logic lowFlowAlarm_q
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  sequence s_stall;
    txValid_q && !txReady;
  endsequence
  sequence s_held;
    txValid_q && $stable(txByte_q);
  endsequence
  a_opt_reset: assert property (
    $rose(resetn) |-> optionBits_q == 16'h0000)
    else $error("option register not clear after reset");
  a_opt_mask: assert property (
    (optionBits_q & 16'hFE60) == 16'h0000)
    else $error("reserved option bit set");
  a_low_flow: assert property ($past(resetn) |->
    lowFlowAlarm_q == $past(lowFlowRaw && !optionBits_q[8]))
    else $error("low flow alarm not gated by option");
  a_pulse_once: assert property (startTest_q |=> !startTest_q)
    else $error("start pulse longer than one cycle");
  a_pulse_solo: assert property (
    $onehot0({startTest_q, recomputeOutcome_q,
    abortTest_q, recordErase_q, recordSeekEnd_q, recordStepBack_q}))
    else $error("two action pulses at once");
  a_abort_stop: assert property (
    abortTest_q |-> ##[0:1] !testRunning_q)
    else $error("abort left test running");
  a_start_run: assert property (
    startTest_q |-> ##[0:1] testRunning_q)
    else $error("start did not set running");
  a_led_idle: assert property (
    !exerciseMode_q [*2] |-> !ledFlash_q)
    else $error("led flashing outside exercise mode");
  a_exer_relay: assert property (exerciseMode_q [*3] |->
    relayAState_q != relayBState_q)
    else $error("relays not alternating in exercise mode");
  a_tx_hold: assert property (s_stall |=> s_held)
    else $error("response byte changed while stalled");
endmodule // mrb_assertions
bind mrb_top mrb_assertions u_mrb_assertions (
  .sys_clk(sys_clk), .resetn(resetn), .txReady(txReady),
  .txValid_q(txValid_q), .txByte_q(txByte_q), .lowFlowRaw(lowFlowRaw),
  .optionBits_q(optionBits_q), .startTest_q(startTest_q),
  .recomputeOutcome_q(recomputeOutcome_q), .abortTest_q(abortTest_q),
  .recordErase_q(recordErase_q), .recordSeekEnd_q(recordSeekEnd_q),
  .recordStepBack_q(recordStepBack_q), .testRunning_q(testRunning_q),
  .exerciseMode_q(exerciseMode_q), .ledFlash_q(ledFlash_q),
  .relayAState_q(relayAState_q), .relayBState_q(relayBState_q),
  .lowFlowAlarm_q(lowFlowAlarm_q)
);
`default_nettype wire

// file: tb/mrb_master.sv
// modbus master model on the far side of the byte link
`default_nettype none
`include "mrb_defs.vh"
module mrb_master (
  input wire logic sys_clk,
  output logic rxValid,
  output logic [7:0] rxByte,
  output logic txReady,
  input wire logic txValid_q,
  input wire logic [7:0] txByte_q
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] rsp [0:299];
  int rspN = 0;
  logic [15:0] rc = 16'hFFFF;
  logic slow = 1'b0;
  logic [2:0] tick = 3'h0;
  function automatic logic [15:0] crc(input logic [15:0] c,
    input logic [7:0] b);
    c = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++)
      c = c[0] ? (c >> 1) ^ `MRB_CRC_POLY : c >> 1;
    return c;
  endfunction
  initial begin
    rxValid = 1'b0;
    rxByte = 8'h00;
    txReady = 1'b1;
  end
  // slow mode accepts one byte in eight; rc ends at zero on a good frame
  always @(posedge sys_clk) begin
    tick <= tick + 3'h1;
    txReady <= !slow || tick == 3'h7;
    if (txValid_q && txReady) begin
      rsp[rspN] <= txByte_q;
      rspN <= rspN + 1;
      rc <= crc(rc, txByte_q);
    end
  end
  task automatic send(input logic [7:0] a, f, input logic [15:0] r, v,
    input logic bad);
    logic [7:0] fr [0:7];
    logic [15:0] c;
    fr = '{a, f, r[15:8], r[7:0],
      v[15:8], v[7:0], 8'h00, 8'h00};
    c = 16'hFFFF;
    for (int i = 0; i < 6; i++)
      c = crc(c, fr[i]);
    c = c ^ {15'h0000, bad};
    fr[6] = c[7:0];
    fr[7] = c[15:8];
    @(posedge sys_clk);
    rspN <= 0;
    rc <= 16'hFFFF;
    for (int i = 0; i < 8; i++) begin
      rxValid <= 1'b1;
      rxByte <= fr[i];
      @(posedge sys_clk);
    end
    rxValid <= 1'b0;
    rxByte <= ~fr[7];
  endtask
endmodule // mrb_master
`default_nettype wire

// file: tb/tb_mrb_top.sv
// self-checking bench for the modbus register interface
`default_nettype none
`include "mrb_defs.vh"
module tb_mrb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] ADDR = 8'h5A;
  localparam logic [15:0] ID = 16'h1234; // arbitrary value
  localparam logic [3:0] LV [1:13] = '{4'h1, 4'h1, 4'h3, 4'h1, 4'h5,
    4'h1, 4'h9, 4'h1, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  localparam logic [5:0] PU [1:13] = '{6'h01, 6'h02, 6'h00, 6'h00,
    6'h00, 6'h00, 6'h00, 6'h00, 6'h04, 6'h08, 6'h10, 6'h20, 6'h00};
  logic sys_clk, resetn, rxValid, txReady, txValid_q, startLinePin;
  logic testDone, lowFlowRaw, testRunning_q, exerciseMode_q, ledFlash_q;
  logic relayAState_q, relayBState_q, lowFlowAlarm_q;
  logic [7:0] rxByte, txByte_q, slaveAddr;
  logic [15:0] stateCode, cleanCode, optionBits_q;
  logic [2:0] resultFlags;
  logic [5:0] alarmIn, pulse, p0;
  logic [5:0] tog = 6'h00;
  logic [4:0] faultDetect;
  int failures, checked;
  mrb_top #(.ID_CODE(ID), .GAP_CYCLES(32'd20), .BLINK_CYCLES(32'd4))
  u_mrb_top (
    .sys_clk(sys_clk), .resetn(resetn), .rxValid(rxValid),
    .rxByte(rxByte), .txReady(txReady), .txValid_q(txValid_q),
    .txByte_q(txByte_q), .slaveAddr(slaveAddr),
    .startLinePin(startLinePin), .stateCode(stateCode),
    .resultFlags(resultFlags), .testDone(testDone), .alarmIn(alarmIn),
    .faultDetect(faultDetect), .cleanCode(cleanCode),
    .lowFlowRaw(lowFlowRaw), .optionBits_q(optionBits_q),
    .startTest_q(pulse[0]), .recomputeOutcome_q(pulse[1]),
    .abortTest_q(pulse[2]), .recordErase_q(pulse[3]),
    .recordSeekEnd_q(pulse[4]), .recordStepBack_q(pulse[5]),
    .testRunning_q(testRunning_q), .exerciseMode_q(exerciseMode_q),
    .ledFlash_q(ledFlash_q), .relayAState_q(relayAState_q),
    .relayBState_q(relayBState_q), .lowFlowAlarm_q(lowFlowAlarm_q)
  );
  mrb_master u_mrb_master (
    .sys_clk(sys_clk), .rxValid(rxValid), .rxByte(rxByte),
    .txReady(txReady), .txValid_q(txValid_q), .txByte_q(txByte_q)
  );
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // odd pulse counts per action output since the last snapshot
  always @(posedge sys_clk) tog <= tog ^ pulse;
  task automatic close_out;
    if (failures == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask
  function automatic logic [15:0] get(input int i);
    return {u_mrb_master.rsp[3 + 2 * i], u_mrb_master.rsp[4 + 2 * i]};
  endfunction
  // bounded wait for e bytes, then idle past the frame gap
  task automatic resp(input int e);
    int k;
    k = 0;
    while (u_mrb_master.rspN < e && k < (e > 0 ? 3000 : 40)) begin
      @(posedge sys_clk);
      k++;
    end
    repeat (25) @(posedge sys_clk);
    chk(u_mrb_master.rspN, e);
    if (e > 0) begin
      chk(u_mrb_master.rc, 16'h0000);
      chk(u_mrb_master.rsp[0], ADDR);
    end
  endtask
  task automatic rd(input logic [15:0] s, n);
    u_mrb_master.send(ADDR, `MRB_FN_READ, s, n, 1'b0);
    resp(5 + 2 * n);
    chk(u_mrb_master.rsp[1], 16'h0004);
    chk(u_mrb_master.rsp[2], 2 * n);
  endtask
  task automatic wr(input logic [15:0] r, v);
    u_mrb_master.send(ADDR, `MRB_FN_WRITE, r, v, 1'b0);
    resp(8);
    chk({u_mrb_master.rsp[4], u_mrb_master.rsp[5]}, v);
  endtask
  initial begin
    failures = 0;
    checked = 0;
    resetn = 1'b0;
    testDone = 1'b0;
    startLinePin = 1'b1;
    slaveAddr = ADDR;
    stateCode = 16'h0A0B;
    cleanCode = 16'h00C3;
    resultFlags = 3'h5;
    alarmIn = 6'h00;
    faultDetect = 5'h00;
    lowFlowRaw = 1'b1;
    repeat (20) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
    chk(optionBits_q, 16'h0000);
    rd(`MRB_REG_OPT, 16'h0001);
    chk(get(0), 16'h0000);
    rd(`MRB_REG_ID, 16'h0001);
    chk(get(0), ID);
    faultDetect <= 5'h11;
    alarmIn <= 6'h09;
    repeat (3) @(posedge sys_clk);
    faultDetect <= 5'h00;
    u_mrb_master.slow <= 1'b1;
    rd(16'h0000, 16'h007D);
    chk(get(56), cleanCode);
    chk(get(30), stateCode);
    chk(get(28), 16'h0011);
    chk(get(21), 16'h0000);
    chk(get(31),
      {5'h0F, alarmIn, 2'b00, resultFlags});
    u_mrb_master.slow <= 1'b0;
    stateCode <= 16'hB00C;
    rd(`MRB_REG_FLT, 16'h0003);
    chk(get(0), 16'h0011);
    chk(get(2), 16'hB00C);
    wr(`MRB_REG_OPT, 16'hFFFF);
    rd(`MRB_REG_OPT, 16'h0001);
    chk(get(0), 16'h019F);
    chk(lowFlowAlarm_q, 16'h0000);
    wr(`MRB_REG_OPT, 16'h0000);
    chk(lowFlowAlarm_q, 16'h0001);
    alarmIn <= 6'h00;
    for (int c = 1; c <= 13; c++) begin
      p0 = tog;
      wr(`MRB_REG_CMD, c[15:0]);
      chk(tog ^ p0, PU[c]);
      chk({exerciseMode_q, relayBState_q, relayAState_q, testRunning_q} &
        (c == 7 ? 4'h9 : 4'hF), LV[c]);
    end
    wr(`MRB_REG_CMD, `MRB_CMD_START);
    testDone <= 1'b1;
    @(posedge sys_clk);
    testDone <= 1'b0;
    rd(`MRB_REG_FLT, 16'h0001);
    chk(get(0), 16'h0000);
    rd(`MRB_REG_COND, 16'h0001);
    chk(get(0) & 16'h0010, 16'h0010);
    u_mrb_master.send(ADDR, 8'h04, 16'h0000, 16'h0001, 1'b1);
    resp(0);
    u_mrb_master.send(ADDR ^ 8'h01, 8'h04, 16'h0000, 16'h0001, 1'b0);
    resp(0);
    u_mrb_master.send(ADDR, 8'h04, 16'h0000, 16'h007E, 1'b0);
    resp(0);
    rd(`MRB_REG_ID, 16'h0001);
    chk(get(0), ID);
    close_out;
  end
  initial begin
    #300000;
    failures++;
    close_out;
  end
endmodule // tb_mrb_top
`default_nettype wire
